// [rtl/slp_top.sv]
// Notes on behaviour
// RL1: All delays counted in core sample clock cycles.
// RL2: Tone unmatched: freq 318, phase 294, each 24 more when keyed; amp 102.
// RL3: Tone matched: freq and phase at 318, or 342 keyed; amp 342.
// RL4: Parallel unmatched: freq 318, phase 294, each 24 more when keyed; amp 102.
// RL5: Parallel matched: freq and phase 318, or 342 when keyed; amp 342.
// RL6: Sweep unmatched: freq 342, phase 318, each 24 more when keyed; amp 126.
// RL7: Sweep matched: freq and phase 342, or 366 when keyed; amp 366.
// RL8: Delay set by settings only, never data.
module slp_top (
	input  wire logic                        sys_clk_in,
	input  wire logic                        rst_n_in,
	input  wire slp_pkg::slp_mode_t          mode_in,
	input  wire logic                        matched_latency_in,
	input  wire logic                        amplitude_keying_in,
	input  wire logic [slp_pkg::FREQ_W-1:0]  freq_in,
	input  wire logic [slp_pkg::PHASE_W-1:0] phase_in,
	input  wire logic [slp_pkg::AMP_W-1:0]   amp_in,
	input  wire logic                        in_valid_in,
	output logic                             in_ready_out,
	output logic      [slp_pkg::FREQ_W-1:0]  freq_out,
	output logic                             freq_valid_out,
	output logic      [slp_pkg::PHASE_W-1:0] phase_out,
	output logic                             phase_valid_out,
	output logic      [slp_pkg::AMP_W-1:0]   amp_out,
	output logic                             amp_valid_out,
	output logic      [8:0]                  freq_latency_out,
	output logic      [8:0]                  phase_latency_out,
	output logic      [8:0]                  amp_latency_out
);
	import slp_pkg::*;

	localparam int unsigned WORD_W = FREQ_W + PHASE_W + AMP_W;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [DLY_W-1:0] f_lat;
		logic [DLY_W-1:0] p_lat;
		logic [DLY_W-1:0] a_lat;
	} slp_state_t;

	slp_state_t st_q;
	slp_state_t st_d;

	logic [WORD_W-1:0] fifo_word;
	logic              fifo_valid;
	logic              pipe_ready;
	logic [FREQ_W-1:0]  fifo_freq;
	logic [PHASE_W-1:0] fifo_phase;
	logic [AMP_W-1:0]   fifo_amp;

	// ****************************************************************
	// Latency selection
	// ****************************************************************
	// Pure function of settings; data never enters the choice
	function automatic slp_state_t lat_sel(input slp_mode_t m, input logic ml,
		input logic ak);
		slp_state_t r;
		r = '0;
		case (m)
			SLP_MODE_SWEEP: begin
				if (ml) begin
					r.f_lat = ak ? LAT_366 : LAT_342; // RL7
					r.p_lat = r.f_lat; // RL7
					r.a_lat = LAT_366; // RL7
				end else begin
					r.f_lat = ak ? LAT_366 : LAT_342; // RL6
					r.p_lat = ak ? LAT_342 : LAT_318; // RL6
					r.a_lat = LAT_126; // RL6
				end
			end
			SLP_MODE_PAR32: begin
				if (ml) begin
					r.f_lat = ak ? LAT_342 : LAT_318; // RL5
					r.p_lat = r.f_lat; // RL5
					r.a_lat = LAT_342; // RL5
				end else begin
					r.f_lat = ak ? LAT_342 : LAT_318; // RL4
					r.p_lat = ak ? LAT_318 : LAT_294; // RL4
					r.a_lat = LAT_102; // RL4
				end
			end
			default: begin
				if (ml) begin
					r.f_lat = ak ? LAT_342 : LAT_318; // RL3
					r.p_lat = r.f_lat; // RL3
					r.a_lat = LAT_342; // RL3
				end else begin
					r.f_lat = ak ? LAT_342 : LAT_318; // RL2
					r.p_lat = ak ? LAT_318 : LAT_294; // RL2
					r.a_lat = LAT_102; // RL2
				end
			end
		endcase
		return r;
	endfunction

	always_comb begin
		st_d = lat_sel(mode_in, matched_latency_in, amplitude_keying_in); // RL8
	end

	// Settings registered so a change lands on a clean edge
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_q <= lat_sel(slp_mode_t'(MODE_RESET), 1'b0, 1'b0);
		end else begin
			st_q <= st_d;
		end
	end

	assign freq_latency_out  = st_q.f_lat;
	assign phase_latency_out = st_q.p_lat;
	assign amp_latency_out   = st_q.a_lat;

	// ****************************************************************
	// Input buffer
	// ****************************************************************
	// Pipeline accepts every cycle; FIFO absorbs source bursts
	assign pipe_ready = 1'b1;

	slp_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in   (sys_clk_in),
		.rst_n_in     (rst_n_in),
		.wr_data_in   ({freq_in, phase_in, amp_in}),
		.wr_valid_in  (in_valid_in),
		.wr_ready_out (in_ready_out),
		.rd_data_out  (fifo_word),
		.rd_valid_out (fifo_valid),
		.rd_ready_in  (pipe_ready)
	);

	assign fifo_freq  = fifo_word[WORD_W-1 -: FREQ_W];
	assign fifo_phase = fifo_word[PHASE_W+AMP_W-1 -: PHASE_W];
	assign fifo_amp   = fifo_word[AMP_W-1:0];

	// ****************************************************************
	// Delay lines, counted from FIFO output in sample cycles
	// ****************************************************************
	slp_delay #(
		.WIDTH (FREQ_W),
		.DEPTH (512)
	) u_freq_dly (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.data_in    (fifo_freq),
		.valid_in   (fifo_valid),
		.delay_in   (st_q.f_lat), // RL1
		.data_out   (freq_out),
		.valid_out  (freq_valid_out)
	);

	slp_delay #(
		.WIDTH (PHASE_W),
		.DEPTH (512)
	) u_phase_dly (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.data_in    (fifo_phase),
		.valid_in   (fifo_valid),
		.delay_in   (st_q.p_lat), // RL1
		.data_out   (phase_out),
		.valid_out  (phase_valid_out)
	);

	slp_delay #(
		.WIDTH (AMP_W),
		.DEPTH (512)
	) u_amp_dly (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.data_in    (fifo_amp),
		.valid_in   (fifo_valid),
		.delay_in   (st_q.a_lat), // RL1
		.data_out   (amp_out),
		.valid_out  (amp_valid_out)
	);
endmodule

// [rtl/slp_pkg.sv]
package slp_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int unsigned FREQ_W     = 32;
	localparam int unsigned PHASE_W    = 16;
	localparam int unsigned AMP_W      = 12;
	localparam int unsigned DLY_W      = 9;
	localparam int unsigned FIFO_DEPTH = 16;

	// ****************************************************************
	// Latency counts in core sample clock cycles
	// ****************************************************************
	localparam logic [8:0] LAT_102 = 9'h066;
	localparam logic [8:0] LAT_126 = 9'h07E;
	localparam logic [8:0] LAT_294 = 9'h126;
	localparam logic [8:0] LAT_318 = 9'h13E;
	localparam logic [8:0] LAT_342 = 9'h156;
	localparam logic [8:0] LAT_366 = 9'h16E;
	localparam logic [8:0] LAT_MAX = 9'h16E;

	// ****************************************************************
	// Operating modes
	// ****************************************************************
	typedef enum logic [1:0] {
		SLP_MODE_TONE  = 2'h0,
		SLP_MODE_PAR32 = 2'h1,
		SLP_MODE_SWEEP = 2'h3
	} slp_mode_t;

	localparam logic [1:0] MODE_RESET = 2'h0;

endpackage

// [rtl/slp_fifo.sv]
module slp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} slp_fifo_st_t;

	slp_fifo_st_t st_q;
	slp_fifo_st_t st_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic wr_en;
	logic rd_en;

	// ****************************************************************
	// Flags
	// ****************************************************************
	assign wr_ready_out = (st_q.cnt != (AW+1)'(DEPTH));
	assign rd_valid_out = (st_q.cnt != '0);
	assign rd_data_out  = mem[st_q.rp];
	assign wr_en        = wr_valid_in && wr_ready_out;
	assign rd_en        = rd_valid_out && rd_ready_in;

	always_comb begin
		st_d = st_q;
		if (wr_en) begin
			st_d.wp = st_q.wp + 1'b1;
		end
		if (rd_en) begin
			st_d.rp = st_q.rp + 1'b1;
		end
		if (wr_en && !rd_en) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end else if (rd_en && !wr_en) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Storage needs no reset; only the count gates what is read
	always_ff @(posedge sys_clk_in) begin
		if (wr_en) begin
			mem[st_q.wp] <= wr_data_in;
		end
	end
endmodule

// [rtl/slp_delay.sv]
module slp_delay #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 512
) (
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic         [WIDTH-1:0] data_in,
	input  wire logic                     valid_in,
	input  wire logic [$clog2(DEPTH)-1:0] delay_in,
	output logic              [WIDTH-1:0] data_out,
	output logic                          valid_out
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [WIDTH-1:0] data;
		logic valid;
	} slp_dly_st_t;

	slp_dly_st_t st_q;
	slp_dly_st_t st_d;
	logic [WIDTH-1:0] mem_data [DEPTH];
	logic             mem_vld  [DEPTH];
	logic [AW-1:0]    rp;

	// Ring buffer: read point trails write by delay-1, plus output flop
	assign rp        = st_q.wp - delay_in + AW'(1);
	assign data_out  = st_q.data;
	assign valid_out = st_q.valid;

	always_comb begin
		st_d       = st_q;
		st_d.wp    = st_q.wp + 1'b1;
		st_d.data  = mem_data[rp];
		st_d.valid = mem_vld[rp];
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Valid bits cleared at reset so stale entries never emerge
	always_ff @(posedge sys_clk_in) begin
		mem_data[st_q.wp] <= data_in;
		mem_vld[st_q.wp]  <= valid_in && rst_n_in;
		if (!rst_n_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_vld[i] <= 1'b0;
			end
		end
	end
endmodule

// [verif/slp_top_properties.sv]
module slp_top_properties
	import slp_pkg::*;
(
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	input wire slp_mode_t  mode_in,
	input wire logic       matched_latency_in,
	input wire logic       amplitude_keying_in,
	input wire logic       freq_valid_out,
	input wire logic       phase_valid_out,
	input wire logic       amp_valid_out,
	input wire logic [8:0] freq_latency_out,
	input wire logic [8:0] phase_latency_out,
	input wire logic [8:0] amp_latency_out
);
	// Keyed extra delay seen one edge late, as the latency ports are
	logic [8:0] add_q;
	always_ff @(posedge sys_clk_in) add_q <= amplitude_keying_in ? 9'h018 : 9'h000;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_tone_open: assert property (mode_in == SLP_MODE_TONE && !matched_latency_in |=>
		freq_latency_out == LAT_318 + add_q && phase_latency_out == LAT_294 + add_q
		&& amp_latency_out == LAT_102) else $error("tone unmatched latency wrong");
	chk_tone_matched: assert property (mode_in == SLP_MODE_TONE && matched_latency_in |=>
		freq_latency_out == LAT_318 + add_q && phase_latency_out == freq_latency_out
		&& amp_latency_out == LAT_342) else $error("tone matched latency wrong");
	chk_par_open: assert property (mode_in == SLP_MODE_PAR32 && !matched_latency_in |=>
		freq_latency_out == LAT_318 + add_q && phase_latency_out == LAT_294 + add_q
		&& amp_latency_out == LAT_102) else $error("parallel unmatched latency wrong");
	chk_par_matched: assert property (mode_in == SLP_MODE_PAR32 && matched_latency_in |=>
		freq_latency_out == LAT_318 + add_q && phase_latency_out == freq_latency_out
		&& amp_latency_out == LAT_342) else $error("parallel matched latency wrong");
	chk_sweep_open: assert property (mode_in == SLP_MODE_SWEEP && !matched_latency_in |=>
		freq_latency_out == LAT_342 + add_q && phase_latency_out == LAT_318 + add_q
		&& amp_latency_out == LAT_126) else $error("sweep unmatched latency wrong");
	chk_sweep_matched: assert property (mode_in == SLP_MODE_SWEEP && matched_latency_in |=>
		freq_latency_out == LAT_342 + add_q && phase_latency_out == freq_latency_out
		&& amp_latency_out == LAT_366) else $error("sweep matched latency wrong");
	chk_fields_together: assert property (freq_latency_out == phase_latency_out |->
		freq_valid_out == phase_valid_out) else $error("frequency and phase split");
	chk_amp_aligned: assert property (amp_latency_out == freq_latency_out |->
		amp_valid_out == freq_valid_out) else $error("amplitude not aligned");
endmodule

bind slp_top slp_top_properties u_props (.sys_clk_in, .rst_n_in, .mode_in, .matched_latency_in,
	.amplitude_keying_in, .freq_valid_out, .phase_valid_out, .amp_valid_out, .freq_latency_out,
	.phase_latency_out, .amp_latency_out);

// [verif/slp_dac_model.sv]
module slp_dac_model (
	input  wire logic        sys_clk_in,
	input  wire logic        freq_valid_in,
	input  wire logic        phase_valid_in,
	input  wire logic        amp_valid_in,
	input  wire logic [59:0] word_in,
	output int               cyc_out,
	output int               f_at_out,
	output int               p_at_out,
	output int               a_at_out,
	output int               f_cnt_out,
	output logic      [59:0] seen_out
);
	// Sink only: the converter takes a sample every cycle, never stalls
	always_ff @(posedge sys_clk_in) begin
		cyc_out <= cyc_out + 1;
		if (freq_valid_in) begin
			f_at_out <= cyc_out;
			f_cnt_out <= f_cnt_out + 1;
			seen_out[59:28] <= word_in[59:28];
		end
		if (phase_valid_in) begin
			p_at_out <= cyc_out;
			seen_out[27:12] <= word_in[27:12];
		end
		if (amp_valid_in) begin
			a_at_out <= cyc_out;
			seen_out[11:0] <= word_in[11:0];
		end
	end
endmodule

// [verif/slp_top_bench.sv]
module slp_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import slp_pkg::*;
	logic               sys_clk_in, rst_n_in, matched_latency_in, amplitude_keying_in;
	logic               in_valid_in, in_ready_out, freq_valid_out, phase_valid_out, amp_valid_out;
	slp_mode_t          mode_in;
	logic [FREQ_W-1:0]  freq_in, freq_out;
	logic [PHASE_W-1:0] phase_in, phase_out;
	logic [AMP_W-1:0]   amp_in, amp_out;
	logic [8:0]         freq_latency_out, phase_latency_out, amp_latency_out;
	logic [59:0]        w, seen;
	logic [26:0]        e;
	int                 error_cnt, comparisons, t0, n0, cyc, f_at, p_at, a_at, f_cnt;
	slp_mode_t          md_list [3] = '{SLP_MODE_TONE, SLP_MODE_PAR32, SLP_MODE_SWEEP};
	slp_top u_dut (.sys_clk_in, .rst_n_in, .mode_in, .matched_latency_in, .amplitude_keying_in,
		.freq_in, .phase_in, .amp_in, .in_valid_in, .in_ready_out, .freq_out, .freq_valid_out,
		.phase_out, .phase_valid_out, .amp_out, .amp_valid_out, .freq_latency_out,
		.phase_latency_out, .amp_latency_out);
	slp_dac_model u_dac (.sys_clk_in, .freq_valid_in(freq_valid_out),
		.phase_valid_in(phase_valid_out), .amp_valid_in(amp_valid_out),
		.word_in({freq_out, phase_out, amp_out}), .cyc_out(cyc), .f_at_out(f_at),
		.p_at_out(p_at), .a_at_out(a_at), .f_cnt_out(f_cnt), .seen_out(seen));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [26:0] exp_lat(input logic [1:0] md, input logic m, input logic k);
		logic [8:0] f;
		logic [8:0] a;
		f = (md == 2'h3 ? 9'h156 : 9'h13E) + (k ? 9'h018 : 9'h000);
		a = m ? (md == 2'h3 ? 9'h16E : 9'h156) : (md == 2'h3 ? 9'h07E : 9'h066);
		return {f, m ? f : f - 9'h018, a};
	endfunction
	// Holds valid for n back-to-back words; t0 is the cycle the last word is offered
	task automatic send(input int n);
		in_valid_in = 1'b1;
		for (int k = 0; k < n; k++) begin
			{freq_in, phase_in, amp_in} = w + 60'(k);
			check(64'(in_ready_out), 64'h1);
			t0 = cyc;
			@(posedge sys_clk_in);
			#1;
		end
		in_valid_in = 1'b0;
	endtask
	task automatic end_of_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		#600000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		{rst_n_in, matched_latency_in, amplitude_keying_in, in_valid_in} = 4'h0;
		mode_in = SLP_MODE_TONE;
		w = '0;
		{freq_in, phase_in, amp_in} = '0;
		repeat (20) @(posedge sys_clk_in);
		#1 rst_n_in = 1'b1;
		check({freq_latency_out, phase_latency_out, amp_latency_out}, exp_lat(2'h0, 0, 0));
		foreach (md_list[i]) begin
			for (int j = 0; j < 4; j++) begin
				mode_in = md_list[i];
				matched_latency_in = j[1];
				amplitude_keying_in = j[0];
				e = exp_lat(mode_in, j[1], j[0]);
				w = 60'hA5C30F961E2D4B7 ^ 60'(i * 4 + j);
				repeat (2) @(posedge sys_clk_in);
				#1 check({freq_latency_out, phase_latency_out, amp_latency_out}, e);
				send(1);
				repeat (380) @(posedge sys_clk_in);
				#1 check(64'(f_at - t0), 64'(e[26:18]) + 1);
				check(64'(p_at - t0), 64'(e[17:9]) + 1);
				check(64'(a_at - t0), 64'(e[8:0]) + 1);
				check(seen, w);
			end
		end
		// Full FIFO depth back to back: no word may be lost or slowed
		n0 = f_cnt;
		w = 60'h0FEDCBA98765432;
		send(FIFO_DEPTH);
		repeat (380) @(posedge sys_clk_in);
		#1 check(64'(f_cnt - n0), 64'(FIFO_DEPTH));
		check(seen, w + 60'(FIFO_DEPTH - 1));
		end_of_test();
	end
endmodule
